//--- design/hsr_id_rom.sv
// read-only identity words and configuration readback with registered read data
`timescale 1ns/100ps

module hsr_id_rom import hsr_pkg::*; #(
  parameter logic [15:0] MAKER_CODE = 16'h0000,
  parameter logic [15:0] PART_CODE  = 16'h0000
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic                    rd_en,
  input  wire logic [7:0]              rd_addr,
  input  wire logic [HSR_SERIAL_W-1:0] unit_serial_bits,
  input  wire logic [15:0]             cfg_word,
  output logic      [15:0]             rd_word,
  output logic                         rd_hit
);

  logic [15:0] word_reg;
  logic [15:0] word_next;
  logic        hit_reg;
  logic        hit_next;

  // ------------------------------------------------------------------
  // word select, held until the next read so the answer stays steady
  // ------------------------------------------------------------------
  always_comb begin
    word_next = word_reg;
    hit_next  = hit_reg;
    if (rd_en) begin
      hit_next = hsr_is_mapped(rd_addr);
      unique case (rd_addr)
        HSR_OFS_CONFIG:    word_next = cfg_word;
        HSR_OFS_SERIAL_HI: word_next = unit_serial_bits[HSR_SN_HI_MSB:HSR_SN_HI_LSB];
        HSR_OFS_SERIAL_MD: word_next = unit_serial_bits[HSR_SN_MD_MSB:HSR_SN_MD_LSB];
        HSR_OFS_SERIAL_LO: word_next = {unit_serial_bits[HSR_SN_LO_MSB:HSR_SN_LO_LSB],
                                        HSR_SN_PAD};
        HSR_OFS_MAKER:     word_next = MAKER_CODE;
        HSR_OFS_PART:      word_next = PART_CODE;
        default:           word_next = HSR_WORD_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      word_reg <= HSR_WORD_ZERO;
      hit_reg  <= 1'b0;
    end else begin
      word_reg <= word_next;
      hit_reg  <= hit_next;
    end
  end

  assign rd_word = word_reg;
  assign rd_hit  = hit_reg;

endmodule // hsr_id_rom

//--- design/hsr_regs.sv
// top of the sensor configuration and identity register bank
`timescale 1ns/100ps

module hsr_regs import hsr_pkg::*; #(
  parameter logic [15:0] MAKER_CODE = 16'h00a5, // arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h005a  // arbitrary value
) (
  input  wire logic                    clk_sys,
  input  wire logic                    resetn,
  input  wire logic                    rd_req,
  input  wire logic [7:0]              rd_addr,
  output logic                         rd_ready,
  output logic                         rd_valid,
  output logic      [15:0]             rd_data,
  output logic                         rd_err,
  input  wire logic                    wr_req,
  input  wire logic [7:0]              wr_addr,
  input  wire logic [15:0]             wr_data,
  output logic                         wr_ready,
  output logic                         wr_err,
  input  wire logic [HSR_SERIAL_W-1:0] unit_serial_bits,
  output logic      [4:0]              hum_res_bits,
  output logic      [4:0]              temp_res_bits
);

  // ------------------------------------------------------------------
  // reset release
  // ------------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;
  logic rst_n;

  // two stages so the release never lands close to a clock edge
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // internal reset, lifts two edges after resetn rises
  assign rst_n = rst_sync_reg;

  // ------------------------------------------------------------------
  // request sequencer
  // ------------------------------------------------------------------
  hsr_state_t state_reg;
  hsr_state_t state_next;
  logic       rd_take;
  logic       wr_take;

  // reads win over a write offered in the same cycle
  assign rd_take  = (state_reg == HSR_ST_IDLE) && rd_req;
  assign wr_take  = (state_reg == HSR_ST_IDLE) && wr_req && !rd_req;
  assign rd_ready = (state_reg == HSR_ST_IDLE);
  assign wr_ready = (state_reg == HSR_ST_IDLE) && !rd_req;

  // the answer cycle blocks new requests for exactly one cycle
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      HSR_ST_IDLE: begin
        if (rd_take) begin
          state_next = HSR_ST_ANSWER;
        end
      end
      HSR_ST_ANSWER: begin
        state_next = HSR_ST_IDLE;
      end
      default: begin
        state_next = HSR_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= HSR_ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------------
  // configuration register, resolution bits only
  // ------------------------------------------------------------------
  logic [1:0]  hres_reg;
  logic [1:0]  hres_next;
  logic        tres_reg;
  logic        tres_next;
  logic        wr_err_reg;
  logic        wr_err_next;
  logic [15:0] cfg_word;

  // low reserved bits are dropped; the host is expected to send zeros there
  always_comb begin
    hres_next   = hres_reg;
    tres_next   = tres_reg;
    wr_err_next = 1'b0;
    if (wr_take) begin
      if (wr_addr == HSR_OFS_CONFIG) begin
        hres_next = wr_data[HSR_CFG_HRES_MSB:HSR_CFG_HRES_LSB];
        tres_next = wr_data[HSR_CFG_TRES_BIT];
      end else begin
        wr_err_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hres_reg   <= HSR_HRES_14;
      tres_reg   <= HSR_TRES_14;
      wr_err_reg <= 1'b0;
    end else begin
      hres_reg   <= hres_next;
      tres_reg   <= tres_next;
      wr_err_reg <= wr_err_next;
    end
  end

  assign wr_err = wr_err_reg;

  // readback: only the resolution bits are held, the rest reads zero
  always_comb begin
    cfg_word = HSR_WORD_ZERO;
    cfg_word[HSR_CFG_TRES_BIT] = tres_reg;
    cfg_word[HSR_CFG_HRES_MSB:HSR_CFG_HRES_LSB] = hres_reg;
  end

  // ------------------------------------------------------------------
  // resolution outputs toward the conversion logic
  // ------------------------------------------------------------------
  logic [4:0] hum_dec;
  logic [4:0] temp_dec;
  logic [4:0] hum_bits_reg;
  logic [4:0] temp_bits_reg;

  hsr_res_decode u_decode (
    .hres_field (hres_reg),
    .tres_sel   (tres_reg),
    .hum_bits   (hum_dec),
    .temp_bits  (temp_dec)
  );

  // registered so the converter sees a width that never glitches
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hum_bits_reg  <= HSR_BITS_14;
      temp_bits_reg <= HSR_BITS_14;
    end else begin
      hum_bits_reg  <= hum_dec;
      temp_bits_reg <= temp_dec;
    end
  end

  assign hum_res_bits  = hum_bits_reg;
  assign temp_res_bits = temp_bits_reg;

  // ------------------------------------------------------------------
  // read data path
  // ------------------------------------------------------------------
  logic rom_hit;

  // serial and codes are fixed, so no path exists that could overwrite them
  hsr_id_rom #(
    .MAKER_CODE (MAKER_CODE),
    .PART_CODE  (PART_CODE)
  ) u_rom (
    .clk_sys          (clk_sys),
    .rst_n            (rst_n),
    .rd_en            (rd_take),
    .rd_addr          (rd_addr),
    .unit_serial_bits (unit_serial_bits),
    .cfg_word         (cfg_word),
    .rd_word          (rd_data),
    .rd_hit           (rom_hit)
  );

  assign rd_valid = (state_reg == HSR_ST_ANSWER);
  assign rd_err   = (state_reg == HSR_ST_ANSWER) && !rom_hit;

  // ------------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  property p_hres_14;
    (wr_take && wr_addr == HSR_OFS_CONFIG &&
     wr_data[HSR_CFG_HRES_MSB:HSR_CFG_HRES_LSB] == HSR_HRES_14)
      |-> ##2 hum_res_bits == HSR_BITS_14;
  endproperty
  a_hres_14: assert property (p_hres_14) else $error("humidity 14-bit not selected");

  property p_hres_8;
    (wr_take && wr_addr == HSR_OFS_CONFIG &&
     wr_data[HSR_CFG_HRES_MSB:HSR_CFG_HRES_LSB] == HSR_HRES_8)
      |-> ##2 hum_res_bits == HSR_BITS_8;
  endproperty
  a_hres_8: assert property (p_hres_8) else $error("humidity 8-bit not selected");

  property p_tres_11;
    (wr_take && wr_addr == HSR_OFS_CONFIG && wr_data[HSR_CFG_TRES_BIT])
      |-> ##2 temp_res_bits == HSR_BITS_11;
  endproperty
  a_tres_11: assert property (p_tres_11) else $error("temperature 11-bit not selected");

  property p_serial_ro;
    (wr_take && wr_addr == HSR_OFS_SERIAL_HI) |=> wr_err && $stable(cfg_word);
  endproperty
  a_serial_ro: assert property (p_serial_ro) else $error("serial write not refused");

  property p_sn_hi;
    (rd_take && rd_addr == HSR_OFS_SERIAL_HI)
      |=> rd_valid && !rd_err && rd_data == unit_serial_bits[HSR_SN_HI_MSB:HSR_SN_HI_LSB];
  endproperty
  a_sn_hi: assert property (p_sn_hi) else $error("serial high word wrong");

  property p_sn_md;
    (rd_take && rd_addr == HSR_OFS_SERIAL_MD)
      |=> rd_valid && rd_data == unit_serial_bits[HSR_SN_MD_MSB:HSR_SN_MD_LSB];
  endproperty
  a_sn_md: assert property (p_sn_md) else $error("serial middle word wrong");

  property p_sn_lo;
    (rd_take && rd_addr == HSR_OFS_SERIAL_LO)
      |=> rd_valid && rd_data[15:HSR_SN_PAD_W] ==
          unit_serial_bits[HSR_SN_LO_MSB:HSR_SN_LO_LSB];
  endproperty
  a_sn_lo: assert property (p_sn_lo) else $error("serial low word wrong");

  property p_sn_pad;
    (rd_take && rd_addr == HSR_OFS_SERIAL_LO) ##1 rd_valid
      |-> rd_data[HSR_SN_PAD_W-1:0] == HSR_SN_PAD;
  endproperty
  a_sn_pad: assert property (p_sn_pad) else $error("serial reserved bits not zero");

  property p_maker;
    (rd_take && rd_addr == HSR_OFS_MAKER) |=> rd_valid && rd_data == MAKER_CODE;
  endproperty
  a_maker: assert property (p_maker) else $error("maker code wrong");

  property p_part;
    (rd_take && rd_addr == HSR_OFS_PART) |=> rd_valid && rd_data == PART_CODE ##1 rd_ready;
  endproperty
  a_part: assert property (p_part) else $error("part code wrong");

  property p_hres_11;
    (wr_take && wr_addr == HSR_OFS_CONFIG &&
     wr_data[HSR_CFG_HRES_MSB:HSR_CFG_HRES_LSB] == HSR_HRES_11)
      |-> ##2 hum_res_bits == HSR_BITS_11;
  endproperty
  a_hres_11: assert property (p_hres_11) else $error("humidity 11-bit not selected");

  property p_tres_14;
    (wr_take && wr_addr == HSR_OFS_CONFIG && !wr_data[HSR_CFG_TRES_BIT])
      |-> ##2 temp_res_bits == HSR_BITS_14;
  endproperty
  a_tres_14: assert property (p_tres_14) else $error("temperature 14-bit not selected");

  // no write can be taken in the take cycle, so the readback matches the held fields
  property p_cfg_rb;
    (rd_take && rd_addr == HSR_OFS_CONFIG) |=> rd_valid && !rd_err && rd_data == cfg_word;
  endproperty
  a_cfg_rb: assert property (p_cfg_rb) else $error("config readback wrong");

  property p_ro_refused;
    (wr_take && wr_addr != HSR_OFS_CONFIG) |=> wr_err;
  endproperty
  a_ro_refused: assert property (p_ro_refused) else $error("read-only write not refused");

  property p_cfg_accepted;
    (wr_take && wr_addr == HSR_OFS_CONFIG) |=> !wr_err;
  endproperty
  a_cfg_accepted: assert property (p_cfg_accepted) else $error("config write refused");

  property p_cov_serial;
    rd_take && rd_addr == HSR_OFS_SERIAL_HI ##1 rd_valid;
  endproperty
  c_cov_serial: cover property (p_cov_serial);

  property p_cov_cfg_rb;
    wr_take && wr_addr == HSR_OFS_CONFIG ##[1:4] rd_take && rd_addr == HSR_OFS_CONFIG;
  endproperty
  c_cov_cfg_rb: cover property (p_cov_cfg_rb);

  property p_cov_unmapped;
    rd_take && !hsr_is_mapped(rd_addr) ##1 rd_err;
  endproperty
  c_cov_unmapped: cover property (p_cov_unmapped);

endmodule // hsr_regs

//--- design/hsr_res_decode.sv
// decode of the humidity and temperature resolution fields into conversion widths
`timescale 1ns/100ps

module hsr_res_decode import hsr_pkg::*; (
  input  wire logic [1:0] hres_field,
  input  wire logic       tres_sel,
  output logic      [4:0] hum_bits,
  output logic      [4:0] temp_bits
);

  // ------------------------------------------------------------------
  // humidity field; code 11 is undefined and falls back to full width
  // ------------------------------------------------------------------
  always_comb begin
    unique case (hres_field)
      HSR_HRES_14: hum_bits = HSR_BITS_14;
      HSR_HRES_11: hum_bits = HSR_BITS_11;
      HSR_HRES_8:  hum_bits = HSR_BITS_8;
      default:     hum_bits = HSR_BITS_14;
    endcase
  end

  // single temperature select bit
  always_comb begin
    temp_bits = (tres_sel == HSR_TRES_11) ? HSR_BITS_11 : HSR_BITS_14;
  end

endmodule // hsr_res_decode

//--- inc/hsr_pkg.sv
// shared constants, types and helpers of the sensor configuration and id register bank
package hsr_pkg;

  // ------------------------------------------------------------------
  // register offsets on the register port
  // ------------------------------------------------------------------
  localparam logic [7:0] HSR_OFS_CONFIG    = 8'h02;
  localparam logic [7:0] HSR_OFS_SERIAL_HI = 8'hfb;
  localparam logic [7:0] HSR_OFS_SERIAL_MD = 8'hfc;
  localparam logic [7:0] HSR_OFS_SERIAL_LO = 8'hfd;
  localparam logic [7:0] HSR_OFS_MAKER     = 8'hfe;
  localparam logic [7:0] HSR_OFS_PART      = 8'hff;

  // ------------------------------------------------------------------
  // field layouts
  // ------------------------------------------------------------------
  localparam int HSR_CFG_TRES_BIT  = 10;
  localparam int HSR_CFG_HRES_MSB  = 9;
  localparam int HSR_CFG_HRES_LSB  = 8;
  localparam int HSR_SERIAL_W      = 41;
  localparam int HSR_SN_HI_MSB     = 40;
  localparam int HSR_SN_HI_LSB     = 25;
  localparam int HSR_SN_MD_MSB     = 24;
  localparam int HSR_SN_MD_LSB     = 9;
  localparam int HSR_SN_LO_MSB     = 8;
  localparam int HSR_SN_LO_LSB     = 0;
  localparam int HSR_SN_PAD_W      = 7;
  localparam logic [6:0] HSR_SN_PAD = 7'h00;

  // ------------------------------------------------------------------
  // reset values and resolution encodings
  // ------------------------------------------------------------------
  localparam logic [15:0] HSR_WORD_ZERO = 16'h0000;
  localparam logic [1:0]  HSR_HRES_14   = 2'h0;
  localparam logic [1:0]  HSR_HRES_11   = 2'h1;
  localparam logic [1:0]  HSR_HRES_8    = 2'h2;
  localparam logic        HSR_TRES_14   = 1'b0;
  localparam logic        HSR_TRES_11   = 1'b1;
  localparam logic [4:0]  HSR_BITS_14   = 5'h0e;
  localparam logic [4:0]  HSR_BITS_11   = 5'h0b;
  localparam logic [4:0]  HSR_BITS_8    = 5'h08;

  // register port sequencer states
  typedef enum logic [1:0] {
    HSR_ST_IDLE   = 2'b01,
    HSR_ST_ANSWER = 2'b10
  } hsr_state_t;

  // true for any offset that the bank answers
  function automatic logic hsr_is_mapped(input logic [7:0] addr);
    return (addr == HSR_OFS_CONFIG) || (addr == HSR_OFS_SERIAL_HI) ||
           (addr == HSR_OFS_SERIAL_MD) || (addr == HSR_OFS_SERIAL_LO) ||
           (addr == HSR_OFS_MAKER) || (addr == HSR_OFS_PART);
  endfunction

endpackage

//--- tb/hsr_host_model.sv
// host-side model of the register link: one read or write at a time
`timescale 1ns/100ps

module hsr_host_model import hsr_pkg::*; (
  input  wire logic        clk_sys,
  output logic             rd_req,
  output logic [7:0]       rd_addr,
  input  wire logic        rd_ready,
  input  wire logic        rd_valid,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_err,
  output logic             wr_req,
  output logic [7:0]       wr_addr,
  output logic [15:0]      wr_data,
  input  wire logic        wr_ready,
  input  wire logic        wr_err
);
  // idle link at time zero
  initial begin
    rd_req  = 1'b0;
    rd_addr = 8'h00;
    wr_req  = 1'b0;
    wr_addr = 8'h00;
    wr_data = 16'h0000;
  end

  // ----------------------------------------------------------------
  // read: hold until ready seen, released lines show the inverse
  // ----------------------------------------------------------------
  // this host never triggers a conversion, so acquisitions stay well under one per second
  task automatic read_reg(input logic [7:0] addr, output logic [15:0] data, output logic err);
    int n;
    n = 0;
    @(posedge clk_sys);
    rd_req  <= 1'b1;
    rd_addr <= addr;
    @(negedge clk_sys);
    while (rd_ready !== 1'b1 && n < 20) begin
      n++;
      @(negedge clk_sys);
    end
    @(posedge clk_sys);
    rd_req  <= 1'b0;
    rd_addr <= ~addr; // stale address must not look valid
    @(negedge clk_sys);
    data = (rd_valid === 1'b1) ? rd_data : 16'hxxxx;
    err  = rd_err;
  endtask

  // ----------------------------------------------------------------
  // write: config low byte always sent as zeros
  // ----------------------------------------------------------------
  task automatic write_reg(input logic [7:0] addr, input logic [15:0] data, output logic err);
    int n;
    n = 0;
    @(posedge clk_sys);
    wr_req  <= 1'b1;
    wr_addr <= addr;
    wr_data <= (addr == HSR_OFS_CONFIG) ? {data[15:8], 8'h00} : data;
    @(negedge clk_sys);
    while (wr_ready !== 1'b1 && n < 20) begin
      n++;
      @(negedge clk_sys);
    end
    @(posedge clk_sys);
    wr_req  <= 1'b0;
    wr_addr <= ~addr;
    wr_data <= ~data;
    @(negedge clk_sys);
    err = wr_err;
  endtask
endmodule // hsr_host_model

//--- tb/hsr_regs_tb.sv
// self-checking testbench of the configuration and identity register bank
`timescale 1ns/100ps

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
  $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

module hsr_regs_tb import hsr_pkg::*;;
  localparam logic [15:0] TB_MAKER = 16'h3c21; // arbitrary value
  localparam logic [15:0] TB_PART  = 16'h7e04; // arbitrary value
  localparam logic [40:0] SERIAL   = 41'h1_5a3c_9e71_b4;
  localparam int          TIMEOUT  = 3000;

  logic        clk_sys;
  logic        resetn;
  logic        rd_req, rd_ready, rd_valid, rd_err;
  logic        wr_req, wr_ready, wr_err;
  logic [7:0]  rd_addr, wr_addr;
  logic [15:0] rd_data, wr_data, rdw;
  logic [4:0]  hum_res_bits, temp_res_bits;
  logic        err;
  logic [15:0] exp_w [5];
  logic [4:0]  exp_hum;
  int          miscompares, samples_checked, cycles;

  hsr_regs #(.MAKER_CODE(TB_MAKER), .PART_CODE(TB_PART)) u_dut (
    .clk_sys(clk_sys), .resetn(resetn), .rd_req(rd_req), .rd_addr(rd_addr),
    .rd_ready(rd_ready), .rd_valid(rd_valid), .rd_data(rd_data), .rd_err(rd_err),
    .wr_req(wr_req), .wr_addr(wr_addr), .wr_data(wr_data), .wr_ready(wr_ready),
    .wr_err(wr_err), .unit_serial_bits(SERIAL), .hum_res_bits(hum_res_bits),
    .temp_res_bits(temp_res_bits));

  hsr_host_model u_host (
    .clk_sys(clk_sys), .rd_req(rd_req), .rd_addr(rd_addr), .rd_ready(rd_ready),
    .rd_valid(rd_valid), .rd_data(rd_data), .rd_err(rd_err), .wr_req(wr_req),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_ready(wr_ready), .wr_err(wr_err));

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ends a run that hangs; a stuck handshake already gives up after 20 cycles
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    miscompares = 0;
    samples_checked = 0;
    exp_w = '{SERIAL[40:25], SERIAL[24:9], {SERIAL[8:0], 7'h00}, TB_MAKER, TB_PART};
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK(hum_res_bits, HSR_BITS_14)
    `CHK(temp_res_bits, HSR_BITS_14)
    $display("test reset_values done");

    // identity words read back to back, offsets fb to ff
    for (int i = 0; i < 5; i++) begin
      u_host.read_reg(HSR_OFS_SERIAL_HI + 8'(i), rdw, err);
      `CHK(rdw, exp_w[i])
      `CHK(err, 1'b0)
    end
    u_host.read_reg(HSR_OFS_SERIAL_HI, rdw, err);
    `CHK(rdw, SERIAL[40:25])
    u_host.read_reg(HSR_OFS_SERIAL_MD, rdw, err);
    `CHK(rdw, SERIAL[24:9])
    u_host.read_reg(HSR_OFS_SERIAL_LO, rdw, err);
    `CHK(rdw[15:7], SERIAL[8:0])
    `CHK(rdw[6:0], 7'h00)
    u_host.read_reg(HSR_OFS_MAKER, rdw, err);
    `CHK(rdw, TB_MAKER)
    u_host.read_reg(HSR_OFS_PART, rdw, err);
    `CHK(rdw, TB_PART)
    $display("test identity_read done");

    // writes to read-only words are refused and change nothing
    for (int i = 0; i < 5; i++) begin
      u_host.write_reg(HSR_OFS_SERIAL_HI + 8'(i), 16'hffff, err);
      `CHK(err, 1'b1)
      u_host.read_reg(HSR_OFS_SERIAL_HI + 8'(i), rdw, err);
      `CHK(rdw, exp_w[i])
    end
    $display("test read_only done");

    // every resolution code of both fields; humidity code 11 is kept but runs full width
    for (int c = 0; c < 8; c++) begin
      exp_hum = (c % 4 == 1) ? HSR_BITS_11 : (c % 4 == 2) ? HSR_BITS_8 : HSR_BITS_14;
      u_host.write_reg(HSR_OFS_CONFIG, {5'h00, 1'(c / 4), 2'(c % 4), 8'h00}, err);
      `CHK(err, 1'b0)
      @(negedge clk_sys);
      `CHK(hum_res_bits, exp_hum)
      `CHK(temp_res_bits, (c / 4 == 1) ? HSR_BITS_11 : HSR_BITS_14)
      u_host.read_reg(HSR_OFS_CONFIG, rdw, err);
      `CHK(rdw, {5'h00, 1'(c / 4), 2'(c % 4), 8'h00})
    end
    $display("test resolution_decode done");

    // unmapped offset answers with an error and zero data
    u_host.read_reg(8'h10, rdw, err);
    `CHK(err, 1'b1)
    `CHK(rdw, 16'h0000)
    u_host.write_reg(8'h10, 16'h1234, err);
    `CHK(err, 1'b1)
    $display("test unmapped done");
    complete_run();
  end
endmodule // hsr_regs_tb
